// [interrupt_priority_vectoring_bench.sv]
// Self-checking bench for the interrupt priority block
`timescale 1ns/100ps
module interrupt_priority_vectoring_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, nmi_pin = 1'b0, pready, pslverr;
    logic dfr = 1'b0, dfr_on = 1'b0; // Deferring instruction ends
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h59474248;
    logic [3:0] pmw = 4'h0; // Port mode writes
    logic [3:0] ext = 4'h0; // External request pins
    logic [2:0] instr_len = 3'h2;
    iprv_pkg::iprv_periph_type periph = '0;
    iprv_pkg::iprv_cpu_type cmd = '0, cpu;
    iprv_pkg::iprv_ack_type ack;
    logic [33:0] bus_q[$], be; // Notes: {read, error, data}
    logic [24:0] ack_q[$], ae; // Notes: {server, vector}
    int fail_count = 0, total_checks = 0;
    always #12.5 pclk = ~pclk;
    iprv_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_pin(nmi_pin), .ext_pin(ext),
        .port_mode_write(pmw), .periph(periph), .cpu(cpu), .ack(ack));
    iprv_core_model core (.pclk(pclk), .presetn(presetn), .defer(dfr),
        .instr_len(instr_len), .cmd(cmd), .ack(ack), .cpu(cpu));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    // Vector table: standard words skip the direct-call hole
    function automatic logic [24:0] vec(input logic [3:0] i, input logic s);
        if (s)
            return {1'b1, iprv_pkg::SRV_VEC_BASE + {19'h0, i, 1'b0}};
        return {1'b0, iprv_pkg::STD_VEC_BASE + {18'h0, i[3], i, 1'b0}};
    endfunction : vec
    task automatic check(input string w, input logic [33:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    // Oldest note against each answer; a stray ack meets all ones
    always @(posedge pclk)
    begin
        if (psel && penable && pready)
        begin
            be = bus_q.pop_front();
            check("bus", be, {be[33], pslverr, be[33] ? prdata : 32'h0});
        end
        if (ack.valid)
        begin
            ae = ack_q.size() ? ack_q.pop_front() : '1;
            check("ack", {9'h0, ae}, {9'h0, ack.server, ack.vector});
            check("page", 34'hff, {26'h0, ack.vector[23:16]});
        end
    end
    // Alternate deferred instruction ends while enabled
    always @(posedge pclk)
        if (cpu.instr_done)
            dfr <= dfr_on & ~dfr;
    // One transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [33:0] e);
        int n;
        bus_q.push_back(e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!pready && n < 50);
        if (pready !== 1'b1)
        begin
            fail_count++;
            final_report();
        end
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {2'b10, d});
    endtask : rd
    // One-cycle pulses on core commands, peripherals and mode writes
    task automatic fire(input logic [13:0] c, input logic [11:0] p,
        input logic [3:0] m);
        @(posedge pclk);
        {cmd, periph, pmw} <= {c, p, m};
        @(posedge pclk);
        {cmd, periph, pmw} <= '0;
    endtask : fire
    // Bounded wait for noted acks, then a quiet spell for strays
    task automatic drain();
        int n;
        for (n = 0; n < 3000 && ack_q.size() != 0; n++)
            @(posedge pclk);
        repeat (40) @(posedge pclk);
        if (ack_q.size() != 0)
        begin
            fail_count++;
            final_report();
        end
    endtask : drain
    initial
    begin
        logic [31:0] r;
        logic [14:0] b, m;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), 32'h0);
        apb(1'b0, 8'h18, 32'h0, {2'b11, 32'h0});
        $display("reset values done");
        dfr_on <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            r = rnd();
            b = r[14:0] & 15'h7ffb;
            m = r[30:16];
            instr_len <= r[10:8];
            wr(iprv_pkg::OFS_MASK, {17'h0, m});
            fire(14'h0, {b[0], b[1], b[5], b[6], b[10:7], 1'b0, b[12],
                b[11], 1'b0}, {b[14], b[13], b[4], b[3]});
            rd(iprv_pkg::OFS_PEND, {17'h0, b});
            rd(iprv_pkg::OFS_CAPP, {29'h0, b[12], b[11], 1'b0});
            for (int i = 14; i >= 0; i--)
                if (b[i] && m[i])
                    ack_q.push_back(vec(4'(i), 1'b0));
            fire(14'h0200, 12'h0, 4'h0);
            drain();
            rd(iprv_pkg::OFS_PEND, {17'h0, b & ~m});
            wr(iprv_pkg::OFS_PEND, 32'hffff);
            wr(iprv_pkg::OFS_CAPP, 32'hf);
            fire(14'h0100, 12'h0, 4'h0);
        end
        $display("priority order done");
        wr(iprv_pkg::OFS_MASK, 32'h4020);
        wr(iprv_pkg::OFS_SEL, 32'h0020);
        ack_q.push_back(vec(4'h5, 1'b1));
        ack_q.push_back(vec(4'he, 1'b0));
        fire(14'h0280, 12'h200, 4'h8);
        drain();
        fire(14'h0100, 12'h0, 4'h0);
        fire(14'h0015, 12'h0, 4'h0);
        rd(iprv_pkg::OFS_SEL, 32'h0);
        rd(iprv_pkg::OFS_ENDX, 32'h20);
        ack_q.push_back(vec(4'h5, 1'b0));
        fire(14'h0200, 12'h0, 4'h0);
        drain();
        rd(iprv_pkg::OFS_ENDX, 32'h0);
        wr(iprv_pkg::OFS_SEL, 32'h0020);
        fire(14'h0100, 12'h0, 4'h0);
        ack_q.push_back(vec(4'h5, 1'b1));
        fire(14'h0, 12'h200, 4'h0);
        drain();
        $display("server path done");
        wr(iprv_pkg::OFS_MASK, 32'h0);
        ack_q.push_back(vec(4'hf, 1'b0));
        nmi_pin <= 1'b1;
        ext <= 4'h1;
        repeat (80) @(posedge pclk);
        nmi_pin <= 1'b0;
        ext <= 4'h0;
        drain();
        rd(iprv_pkg::OFS_PEND, 32'h8);
        wr(iprv_pkg::OFS_PEND, 32'hffff);
        $display("nonmaskable done");
        dfr_on <= 1'b0;
        wr(iprv_pkg::OFS_SEL, 32'h0);
        wr(iprv_pkg::OFS_MASK, 32'h0020);
        fire(14'h0200, 12'h0, 4'h0);
        for (int k = 0; k < 2; k++)
        begin
            ack_q.push_back({1'b0, k ? iprv_pkg::TRAP_VEC
                : iprv_pkg::UNDEF_VEC});
            ack_q.push_back(vec(4'h5, 1'b0));
            fire(k ? 14'h0400 : 14'h0800, 12'h200, 4'h0);
            drain();
        end
        fire(14'h0040, 12'h0, 4'h0);
        rd(iprv_pkg::OFS_STAT, 32'hff200a01);
        $display("direct calls done");
        final_report();
    end
endmodule : interrupt_priority_vectoring_bench
bind iprv_controller iprv_sva chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .cpu(cpu), .ack(ack));

// [iprv_controller.sv]
// Interrupt prioritisation, vectoring and register slave
`timescale 1ns/100ps

module iprv_controller
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_pin,
    input wire logic [3:0] ext_pin,
    input wire logic [3:0] port_mode_write,
    input wire iprv_pkg::iprv_periph_type periph,
    input wire iprv_pkg::iprv_cpu_type cpu,
    output iprv_pkg::iprv_ack_type ack
);

    // The block sits between the request sources and the core's
    // sequencer. Requests latch into pending flags, the flags are ranked
    // once per finished instruction, and the winner leaves as a one-cycle
    // acknowledge carrying its vector. The two direct calls skip ranking.
    // Registers on the bus let software mask, steer to the server and
    // clear flags; everything runs on the one core clock.

    // Whole module state in one record
    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] pend;
        logic [15:0] sel;
        logic [15:0] endx;
        logic [3:0] cap_pend;
        logic gen;
        logic sen;
        logic block;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] prev;
        iprv_pkg::iprv_ack_type ack;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } iprv_state_type;

    iprv_state_type s_q; // Registered state
    iprv_state_type s_d; // Next state
    // Keeping every flop in one record means reset clears all of them in
    // one statement; no field can be forgotten and come up unknown.

    // Highest set index; later indices outrank earlier ones
    // Scanning upward and keeping the last hit is small and needs no
    // priority tree; sixteen inputs keep the chain short.
    function automatic logic [3:0] top_index(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < iprv_pkg::NSRC; i++)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : top_index

    // One word per source above the chosen base
    function automatic logic [23:0] vec_of(input logic server,
                                           input logic [3:0] idx);
        logic [23:0] base;
        base = server ? iprv_pkg::SRV_VEC_BASE : iprv_pkg::STD_VEC_BASE;
        // Standard words leave a hole for the two direct calls, so
        // the upper eight standard sources sit 20h higher
        return base + {18'h00000, ~server & idx[3], idx, 1'b0};
    endfunction : vec_of

    // One-hot of an index
    function automatic logic [15:0] bit_of(input logic [3:0] idx);
        return 16'h0001 << idx;
    endfunction : bit_of

    // Working terms of the combinational process
    logic [4:0] rise;
    logic [15:0] hw_set;
    logic [15:0] srv_cand;
    logic [15:0] std_pend;
    logic [15:0] std_endx;
    logic [15:0] maskable;
    logic [3:0] idx;
    logic ack_ok;
    logic access;
    logic [31:0] wmask;

    // Next-state logic: bus, detection, arbitration
    always_comb
    begin
        s_d = s_q;
        idx = 4'h0;
        hw_set = iprv_pkg::RST_16;
        s_d.ack.valid = 1'b0;
        s_d.ack.server = 1'b0;
        s_d.ack.direct = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        wmask = pwdata;

        // Pins are asynchronous: two flops tame metastability before
        // the edge detector looks at them.
        // Two flops before the pin edge detector
        s_d.sync1 = {nmi_pin, ext_pin};
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        // Rising edge only: a held level asks once
        // A brief low dip on a high pin looks like an edge
        rise = s_q.sync2 & ~s_q.prev;

        // Bus access phase, one wait state
        // Answering from a flop costs one cycle per transfer but keeps
        // read data and ready glitch free at the pins; the pready term
        // stops the held request from being taken a second time.
        access = psel & penable & ~s_q.pready;
        if (access)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h00000000;
            unique case (paddr)
                iprv_pkg::OFS_MASK:
                begin
                    s_d.prdata[15:0] = s_q.mask;
                    if (pwrite)
                    begin
                        s_d.mask = pwdata[15:0];
                    end
                end
                iprv_pkg::OFS_PEND:
                begin
                    // Write one to clear; read shows the flags
                    s_d.prdata[15:0] = s_q.pend;
                    if (pwrite)
                    begin
                        s_d.pend = s_q.pend & ~wmask[15:0];
                    end
                end
                iprv_pkg::OFS_SEL:
                begin
                    s_d.prdata[15:0] = s_q.sel;
                    if (pwrite)
                    begin
                        // Nonmaskable can never go to the server
                        s_d.sel = pwdata[15:0] &
                            ~bit_of(iprv_pkg::NMI_IDX);
                    end
                end
                iprv_pkg::OFS_ENDX:
                begin
                    s_d.prdata[15:0] = s_q.endx;
                    if (pwrite)
                    begin
                        s_d.endx = s_q.endx & ~wmask[15:0];
                    end
                end
                iprv_pkg::OFS_STAT:
                begin
                    s_d.prdata[iprv_pkg::ST_GEN] = s_q.gen;
                    s_d.prdata[iprv_pkg::ST_SEN] = s_q.sen;
                    s_d.prdata[iprv_pkg::ST_BLOCK] = s_q.block;
                    s_d.prdata[iprv_pkg::ST_VEC_LO +: 24] = s_q.ack.vector;
                end
                iprv_pkg::OFS_CAPP:
                begin
                    // Source of a shared overrun is read here
                    s_d.prdata[3:0] = s_q.cap_pend;
                    if (pwrite)
                    begin
                        s_d.cap_pend = s_q.cap_pend & ~wmask[3:0];
                    end
                end
                default:
                begin
                    // Unmapped: error answer, read zero
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // Global enables from the core's instructions
        if (cpu.global_enable_instr)
        begin
            s_d.gen = 1'b1;
        end
        else if (cpu.global_disable_instr)
        begin
            s_d.gen = 1'b0;
        end
        if (cpu.server_enable_instr)
        begin
            s_d.sen = 1'b1;
        end
        else if (cpu.server_disable_instr)
        begin
            s_d.sen = 1'b0;
        end

        // Request sources into their fixed slots
        // Each source is a one-cycle pulse; the flag holds it from here.
        hw_set[iprv_pkg::TM1_IDX] = periph.timer_one_overflow;
        hw_set[iprv_pkg::TM2_IDX] = periph.timer_two_overflow;
        hw_set[iprv_pkg::TX_IDX] = periph.serial_transmit_request;
        hw_set[iprv_pkg::RX_IDX] = periph.serial_receive_request;
        hw_set[iprv_pkg::CAP0_IDX +: 4] = periph.capture_compare;
        // Four overruns fold into two shared slots
        hw_set[iprv_pkg::OVR_LO_IDX] = |periph.capture_overrun[1:0];
        hw_set[iprv_pkg::OVR_HI_IDX] = |periph.capture_overrun[3:2];
        // External pins, or a write of their mode bit
        hw_set[iprv_pkg::EXT0_IDX] = rise[0] | port_mode_write[0];
        hw_set[iprv_pkg::EXT1_IDX] = rise[1] | port_mode_write[1];
        hw_set[iprv_pkg::EXT2_IDX] = rise[2] | port_mode_write[2];
        hw_set[iprv_pkg::EXT3_IDX] = rise[3] | port_mode_write[3];
        hw_set[iprv_pkg::NMI_IDX] = rise[4];

        // Masks gate ranking only; a masked source still sets its flag,
        // so unmasking later serves a request that came earlier.
        // Candidates; mask bit 15 does not gate the nonmaskable
        maskable = s_q.mask & ~bit_of(iprv_pkg::NMI_IDX);
        // Server needs mask, select and server enable
        // Global disable does not stop the server
        srv_cand = s_q.pend & maskable & s_q.sel & {16{s_q.sen}};
        // Standard path obeys the global enable
        std_pend = s_q.pend & maskable & ~s_q.sel & {16{s_q.gen}};
        // End requests blocked by global disable
        std_endx = s_q.endx & maskable & {16{s_q.gen}};

        // A request landing in the cycle of an instruction end is seen
        // only at the next end, since ranking reads flop state
        // Ack only at instruction end, not while deferred,
        // blocked, or while a server cycle runs
        ack_ok = cpu.instr_done & ~cpu.defer_instr & ~s_q.block &
            ~cpu.server_busy;

        // Block drops after the following instruction ends
        if (cpu.instr_done)
        begin
            s_d.block = 1'b0;
        end

        // Arbitration order: undefined opcode, trap, then ranked
        // requests. Only one acknowledge leaves per edge; a ranked request that
        // loses stays pending and is looked at again at the next unshadowed instruction
        // end, but a trap that meets an undefined opcode is dropped.
        if (cpu.undef_opcode)
        begin
            // Straight to the controller, no ranking
            s_d.ack.valid = 1'b1;
            s_d.ack.direct = 1'b1;
            s_d.ack.index = 4'h0;
            s_d.ack.vector = iprv_pkg::UNDEF_VEC;
            s_d.block = 1'b1;
        end
        else if (cpu.trap_instr)
        begin
            // Trap call, unranked and never masked
            s_d.ack.valid = 1'b1;
            s_d.ack.direct = 1'b1;
            s_d.ack.index = 4'h0;
            s_d.ack.vector = iprv_pkg::TRAP_VEC;
            s_d.block = 1'b1;
        end
        else if (ack_ok)
        begin
            if (s_q.pend[iprv_pkg::NMI_IDX])
            begin
                // Nonmaskable beats everything ranked
                s_d.ack.valid = 1'b1;
                s_d.ack.index = iprv_pkg::NMI_IDX;
                s_d.ack.vector = iprv_pkg::NMI_VEC;
                s_d.pend[iprv_pkg::NMI_IDX] = 1'b0;
            end
            else if (|srv_cand)
            begin
                // Any server request outranks standard ones
                idx = top_index(srv_cand);
                s_d.ack.valid = 1'b1;
                s_d.ack.server = 1'b1;
                s_d.ack.index = idx;
                s_d.ack.vector = vec_of(1'b1, idx);
                s_d.pend[idx] = 1'b0;
            end
            else if (|(std_pend | std_endx))
            begin
                // End requests rank as their standard source
                idx = top_index(std_pend | std_endx);
                s_d.ack.valid = 1'b1;
                s_d.ack.index = idx;
                s_d.ack.vector = vec_of(1'b0, idx);
                if (std_endx[idx])
                begin
                    s_d.endx[idx] = 1'b0;
                end
                else
                begin
                    s_d.pend[idx] = 1'b0;
                end
            end
        end

        // This runs after the bus decode on purpose: hardware clearing
        // the select bit must win over a software write in one cycle.
        // Count reached zero: stop server, raise end request
        if (cpu.count_zero &&
            cpu.count_zero_index != iprv_pkg::NMI_IDX)
        begin
            s_d.sel[cpu.count_zero_index] = 1'b0;
            s_d.endx[cpu.count_zero_index] = 1'b1;
        end

        // Detected events last so a set beats any clear
        s_d.pend = s_d.pend | hw_set;
        s_d.cap_pend = s_d.cap_pend | periph.capture_overrun;
    end

    // State register
    // Reset loads constants only; the pin synchronisers clear to the
    // idle low level, so no false edge is seen when reset lets go.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from flops
    // No logic stands between these flops and the pins, so the core
    // sees settled values a full cycle before it samples them.
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign ack = s_q.ack;

endmodule : iprv_controller

// [iprv_core_model.sv]
// Core sequencer model: instruction ends and server cycles
`timescale 1ns/100ps
module iprv_core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] instr_len,
    input wire logic defer,
    input wire iprv_pkg::iprv_cpu_type cmd,
    input wire iprv_pkg::iprv_ack_type ack,
    output iprv_pkg::iprv_cpu_type cpu
);
    logic [2:0] cnt_q; // Cycles left in this instruction
    logic [3:0] busy_q; // Cycles left in a server cycle
    // Instructions stall while the server owns the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 3'h0;
            busy_q <= 4'h0;
        end
        else if (ack.valid && ack.server)
            busy_q <= 4'h9;
        else if (busy_q != 4'h0)
            busy_q <= busy_q - 4'h1;
        else
            cnt_q <= (cnt_q == 3'h0) ? instr_len : cnt_q - 3'h1;
    end
    // Bench commands pass through; timing fields are our own
    always_comb
    begin
        cpu = cmd;
        cpu.instr_done = presetn && cnt_q == 3'h0 && busy_q == 4'h0;
        cpu.defer_instr = defer && cpu.instr_done;
        cpu.server_busy = busy_q != 4'h0;
    end
endmodule : iprv_core_model

// [iprv_pkg.sv]
// Shared constants and carrier types for the interrupt priority block
package iprv_pkg;

    // Number of prioritised sources; index 15 is the nonmaskable one
    localparam int NSRC = 16;
    localparam logic [3:0] NMI_IDX = 4'hf;
    localparam logic [3:0] OVR_LO_IDX = 4'hb;
    localparam logic [3:0] OVR_HI_IDX = 4'hc;
    localparam logic [3:0] EXT0_IDX = 4'h3;
    localparam logic [3:0] EXT1_IDX = 4'h4;
    localparam logic [3:0] EXT2_IDX = 4'hd;
    localparam logic [3:0] EXT3_IDX = 4'he;
    localparam logic [3:0] TM1_IDX = 4'h0;
    localparam logic [3:0] TM2_IDX = 4'h1;
    localparam logic [3:0] TX_IDX = 4'h5;
    localparam logic [3:0] RX_IDX = 4'h6;
    localparam logic [3:0] CAP0_IDX = 4'h7;

    // Priority scale ends
    localparam int PRIO_MAX = 30;
    localparam int PRIO_MIN = 0;
    localparam int SERVER_PRIO_BASE = 15;

    // Vector addresses
    localparam logic [23:0] STD_VEC_BASE = 24'hff2000;
    localparam logic [23:0] SRV_VEC_BASE = 24'hff2040;
    localparam logic [23:0] NMI_VEC = 24'hff203e;
    localparam logic [23:0] UNDEF_VEC = 24'hff2012;
    localparam logic [23:0] TRAP_VEC = 24'hff2010;
    localparam logic [7:0] TRAP_OPCODE = 8'hf7;
    localparam logic [7:0] SIGNED_PREFIX_OPCODE = 8'hfe;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_MASK = 8'h00;
    localparam logic [7:0] OFS_PEND = 8'h04;
    localparam logic [7:0] OFS_SEL = 8'h08;
    localparam logic [7:0] OFS_ENDX = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_CAPP = 8'h14;
    localparam logic [15:0] RST_16 = 16'h0000;

    // Status word bit positions
    localparam int ST_GEN = 0;
    localparam int ST_SEN = 1;
    localparam int ST_BLOCK = 2;
    localparam int ST_VEC_LO = 8;

    // Peripheral request pulses, same clock domain
    typedef struct packed {
        logic timer_one_overflow;
        logic timer_two_overflow;
        logic serial_transmit_request;
        logic serial_receive_request;
        logic [3:0] capture_compare;
        logic [3:0] capture_overrun;
    } iprv_periph_type;

    // Core sequencer signals, same clock domain
    typedef struct packed {
        logic instr_done;
        logic defer_instr;
        logic undef_opcode;
        logic trap_instr;
        logic global_enable_instr;
        logic global_disable_instr;
        logic server_enable_instr;
        logic server_disable_instr;
        logic server_busy;
        logic count_zero;
        logic [3:0] count_zero_index;
    } iprv_cpu_type;

    // Acknowledge toward the core
    typedef struct packed {
        logic valid;
        logic server;
        logic direct;
        logic [3:0] index;
        logic [23:0] vector;
    } iprv_ack_type;

endpackage : iprv_pkg

// [iprv_sva.sv]
// Port assertions for the interrupt priority block
`timescale 1ns/100ps
module iprv_sva
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire iprv_pkg::iprv_cpu_type cpu,
    input wire iprv_pkg::iprv_ack_type ack
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic blk_q; // Direct call still shadows one instruction end
    logic [23:0] std_v; // Expected standard vector
    logic [23:0] srv_v; // Expected server vector
    // Standard table skips 10-2f, where the direct calls live
    assign std_v = iprv_pkg::STD_VEC_BASE
        + {18'h0, ack.index[3], ack.index, 1'b0};
    assign srv_v = iprv_pkg::SRV_VEC_BASE + {19'h0, ack.index, 1'b0};
    // Undefined opcode or trap opens a shadow; next end closes it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blk_q <= 1'b0;
        else if (cpu.undef_opcode || cpu.trap_instr)
            blk_q <= 1'b1;
        else if (cpu.instr_done)
            blk_q <= 1'b0;
    end
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer not after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("bus ready longer than one cycle");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("bus error without ready");
    vector_hold_a: assert property (!ack.valid
        |=> ack.valid || $stable(ack.vector))
        else $error("vector changed without an acknowledge");
    undef_call_a: assert property (cpu.undef_opcode
        |=> ack.valid && ack.direct && ack.vector == iprv_pkg::UNDEF_VEC)
        else $error("undefined opcode call wrong");
    trap_call_a: assert property (cpu.trap_instr && !cpu.undef_opcode
        |=> ack.valid && ack.direct && ack.vector == iprv_pkg::TRAP_VEC)
        else $error("trap call wrong");
    ack_at_end_a: assert property (!cpu.undef_opcode
        && !cpu.trap_instr
        && !(cpu.instr_done && !cpu.defer_instr && !cpu.server_busy)
        |=> !ack.valid)
        else $error("acknowledge outside a clean instruction end");
    shadow_block_a: assert property (blk_q && cpu.instr_done
        && !cpu.undef_opcode && !cpu.trap_instr |=> !ack.valid)
        else $error("acknowledge inside call shadow");
    std_vector_a: assert property (ack.valid && !ack.server
        && !ack.direct |-> ack.vector == std_v)
        else $error("standard vector wrong");
    srv_vector_a: assert property (ack.valid && ack.server
        |-> ack.vector == srv_v && !ack.direct
        && ack.index != iprv_pkg::NMI_IDX)
        else $error("server vector wrong");
    cover property (ack.valid && ack.server);
    cover property (ack.valid && ack.index == iprv_pkg::NMI_IDX);
    cover property (blk_q && cpu.instr_done);
    cover property (pready && pslverr);
endmodule : iprv_sva
